// file: src/alc_cal_regs.sv
`timescale 1ns/1ps
module alc_cal_regs
	import alc_pkg::*;
#(
	parameter int       VEC_DEPTH    = VEC_LENGTH,
	parameter int       CAL_CYCLES   = 16,
	parameter logic [7:0] FUSE_GAIN_A  = 8'h80,
	parameter logic [7:0] FUSE_GAIN_B  = 8'h80,
	parameter logic [3:0] FUSE_BANDGAP = 4'h8,
	parameter logic [7:0] FUSE_TERM_A  = 8'h80,
	parameter logic [7:0] FUSE_TERM_B  = 8'h80
)
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       regWrite,
	input  wire logic       regRead,
	input  wire logic [7:0] regAddr,
	input  wire logic [7:0] regWdata,
	output logic      [7:0] regRdata,
	input  wire logic       background_cal_enable,
	input  wire logic       trigger_source_sel,
	input  wire logic       soft_calib_trigger,
	input  wire logic       calib_trigger_pin,
	input  wire logic       calibHalted,
	output logic            coreAwake,
	output logic            calRequest,
	output logic            calDataValid,
	output logic      [7:0] gainAdjustA,
	output logic      [7:0] gainAdjustB,
	output logic      [3:0] bandgapAdjust,
	output logic      [7:0] termAdjustA,
	output logic      [7:0] termAdjustB,
	output logic            dither_enable,
	output logic            dither_amplitude_sel,
	output logic            rounding_error_sel
);

	// ****************************************************************
	// Register storage.
	// ****************************************************************
	localparam int PTR_W = $clog2(VEC_DEPTH + 1);
	localparam int CAL_W = $clog2(CAL_CYCLES + 1);

	logic [7:0]       lpCtrl_r;
	logic             vecEnable_r;
	logic [7:0]       dither_r;
	logic [7:0]       vecMem [VEC_DEPTH];
	logic [PTR_W-1:0] vecPtr_r;
	logic [CAL_W-1:0] calCount_r;
	alc_lp_state_e    lpState_r;

	logic             wrLp;
	logic             wrVecEn;
	logic             wrPort;
	logic             rdPort;
	logic             lowPowerOn;
	logic             calib_trigger_input;
	logic             selectedTrigger;
	logic             autonomousMode;
	logic [2:0]       sleep_interval_sel;
	logic [1:0]       settle_interval_sel;
	logic             trigger_wake_sel;
	logic             lowpower_cal_enable;
	logic [EXP_WIDTH-1:0] sleepExp;
	logic [EXP_WIDTH-1:0] settleExp;
	logic             sleepStart;
	logic             settleStart;
	logic             sleepDone;
	logic             settleDone;
	logic             timerClear;

	// Field views of the low-power control register.
	assign sleep_interval_sel  = lpCtrl_r[SLEEP_SEL_LSB +: 3];
	assign settle_interval_sel = lpCtrl_r[SETTLE_SEL_LSB +: 2];
	assign trigger_wake_sel    = lpCtrl_r[TRIG_WAKE_BIT];
	assign lowpower_cal_enable = lpCtrl_r[LP_ENABLE_BIT];

	// Decode of the register strobes.
	assign wrLp    = regWrite && (regAddr == LP_CTRL_OFS);
	assign wrVecEn = regWrite && (regAddr == VEC_EN_OFS);
	assign wrPort  = regWrite && (regAddr == VEC_PORT_OFS) && vecEnable_r;
	assign rdPort  = regRead && (regAddr == VEC_PORT_OFS) && vecEnable_r;

	// ****************************************************************
	// Control registers.
	// ****************************************************************
	// Low-power control; reserved bit 2 is stored as written since software keeps it zero.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lpCtrl_r <= LP_CTRL_RST;
		end
		else if (wrLp)
		begin
			lpCtrl_r <= regWdata;
		end
	end

	// Vector port enable and dither controls.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			vecEnable_r <= VEC_EN_RST[VEC_EN_BIT];
			dither_r    <= DITHER_RST;
		end
		else
		begin
			if (wrVecEn)
			begin
				vecEnable_r <= regWdata[VEC_EN_BIT];
			end
			if (regWrite && (regAddr == DITHER_OFS))
			begin
				dither_r <= regWdata;
			end
		end
	end

	assign dither_enable        = dither_r[DITH_EN_BIT];
	assign dither_amplitude_sel = dither_r[DITH_AMP_BIT];
	assign rounding_error_sel   = dither_r[DITH_ERR_BIT];

	// Trims take their factory values at reset and are overwritable.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			gainAdjustA   <= FUSE_GAIN_A;
			gainAdjustB   <= FUSE_GAIN_B;
			bandgapAdjust <= FUSE_BANDGAP;
			termAdjustA   <= FUSE_TERM_A;
			termAdjustB   <= FUSE_TERM_B;
		end
		else if (regWrite)
		begin
			if (regAddr == GAIN_A_OFS)
			begin
				gainAdjustA <= regWdata;
			end
			else if (regAddr == GAIN_B_OFS)
			begin
				gainAdjustB <= regWdata;
			end
			else if (regAddr == BANDGAP_OFS)
			begin
				bandgapAdjust <= regWdata[BANDGAP_WIDTH-1:0];
			end
			else if (regAddr == TERM_A_OFS)
			begin
				termAdjustA <= regWdata;
			end
			else if (regAddr == TERM_B_OFS)
			begin
				termAdjustB <= regWdata;
			end
		end
	end

	// ****************************************************************
	// Calibration vector port.
	// ****************************************************************
	// Sequential pointer; the host must only touch the port while halted.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			vecPtr_r     <= '0;
			calDataValid <= 1'b1;
		end
		else if (!vecEnable_r)
		begin
			// Closing the port mid-transfer leaves the data invalid.
			if (vecPtr_r != '0)
			begin
				calDataValid <= 1'b0;
			end
			vecPtr_r <= '0;
		end
		else if (rdPort || wrPort)
		begin
			if (vecPtr_r == PTR_W'(VEC_DEPTH - 1))
			begin
				vecPtr_r     <= '0;
				calDataValid <= 1'b1;
			end
			else
			begin
				vecPtr_r     <= vecPtr_r + PTR_W'(1);
				calDataValid <= 1'b0;
			end
		end
	end

	// Vector storage written one byte per port write.
	always_ff @(posedge sys_clk)
	begin
		if (wrPort)
		begin
			vecMem[vecPtr_r] <= regWdata;
		end
	end

	// ****************************************************************
	// Read data.
	// ****************************************************************
	// Read mux is registered; unmapped addresses and the closed port read zero.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			regRdata <= '0;
		end
		else if (regRead)
		begin
			if (regAddr == LP_CTRL_OFS)
			begin
				regRdata <= lpCtrl_r;
			end
			else if (regAddr == VEC_EN_OFS)
			begin
				regRdata <= {7'h00, vecEnable_r};
			end
			else if (rdPort)
			begin
				regRdata <= vecMem[vecPtr_r];
			end
			else if (regAddr == GAIN_A_OFS)
			begin
				regRdata <= gainAdjustA;
			end
			else if (regAddr == GAIN_B_OFS)
			begin
				regRdata <= gainAdjustB;
			end
			else if (regAddr == BANDGAP_OFS)
			begin
				regRdata <= {4'h0, bandgapAdjust};
			end
			else if (regAddr == TERM_A_OFS)
			begin
				regRdata <= termAdjustA;
			end
			else if (regAddr == TERM_B_OFS)
			begin
				regRdata <= termAdjustB;
			end
			else if (regAddr == DITHER_OFS)
			begin
				regRdata <= dither_r;
			end
			else
			begin
				regRdata <= '0;
			end
		end
	end

	// ****************************************************************
	// Low-power scheduler.
	// ****************************************************************
	alc_sync3 u_trigSync
	(
		.sys_clk    (sys_clk),
		.rst        (rst),
		.asyncIn    (calib_trigger_pin),
		.resetLevel (1'b1),
		.syncOut    (calib_trigger_input)
	);

	// Only one trigger source is heard at a time.
	assign selectedTrigger = trigger_source_sel ? calib_trigger_input
	                                            : soft_calib_trigger;
	assign lowPowerOn      = lowpower_cal_enable && background_cal_enable;
	assign autonomousMode  = lowPowerOn && !trigger_wake_sel;
	assign timerClear      = !lowPowerOn;

	// Exponent tables: 3,15,18,...,33 for sleep and 3,18,21,24 for settling.
	always_comb
	begin
		if (sleep_interval_sel == 3'd0)
		begin
			sleepExp = EXP_WIDTH'(3);
		end
		else
		begin
			sleepExp = EXP_WIDTH'(12 + 3 * int'(sleep_interval_sel));
		end
		if (settle_interval_sel == 2'd0)
		begin
			settleExp = EXP_WIDTH'(3);
		end
		else
		begin
			settleExp = EXP_WIDTH'(15 + 3 * int'(settle_interval_sel));
		end
	end

	alc_interval_timer u_sleepTimer
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (timerClear || !autonomousMode),
		.start   (sleepStart),
		.expK    (sleepExp),
		.done    (sleepDone)
	);

	alc_interval_timer u_settleTimer
	(
		.sys_clk (sys_clk),
		.rst     (rst),
		.clear   (timerClear),
		.start   (settleStart),
		.expK    (settleExp),
		.done    (settleDone)
	);

	// Sleep, settle, calibrate, sleep again; leaving low power drops to idle.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lpState_r   <= ALC_IDLE;
			calCount_r  <= '0;
			sleepStart  <= 1'b0;
			settleStart <= 1'b0;
		end
		else if (!lowPowerOn)
		begin
			lpState_r   <= ALC_IDLE;
			calCount_r  <= '0;
			sleepStart  <= 1'b0;
			settleStart <= 1'b0;
		end
		else
		begin
			sleepStart  <= 1'b0;
			settleStart <= 1'b0;
			case (lpState_r)
				ALC_IDLE:
				begin
					lpState_r  <= ALC_SLEEP;
					sleepStart <= 1'b1;
				end
				ALC_SLEEP:
				begin
					// Trigger mode wakes on a low trigger; otherwise the timer ends sleep.
					if ((trigger_wake_sel && !selectedTrigger) ||
					    (!trigger_wake_sel && sleepDone))
					begin
						lpState_r   <= ALC_SETTLE;
						settleStart <= 1'b1;
					end
				end
				ALC_SETTLE:
				begin
					if (settleDone)
					begin
						lpState_r  <= ALC_CAL;
						calCount_r <= CAL_W'(CAL_CYCLES);
					end
				end
				ALC_CAL:
				begin
					// Calibration pauses while the engine reports a halt.
					if (calCount_r == CAL_W'(1))
					begin
						lpState_r  <= ALC_SLEEP;
						sleepStart <= 1'b1;
					end
					else if (!calibHalted)
					begin
						calCount_r <= calCount_r - CAL_W'(1);
					end
				end
				default:
				begin
					lpState_r <= ALC_IDLE;
				end
			endcase
		end
	end

	// Core runs whenever not asleep; in low power calibration is requested only in its slot, otherwise calRequest follows background_cal_enable.
	assign coreAwake  = !lowPowerOn || (lpState_r != ALC_SLEEP);
	assign calRequest = lowPowerOn ? (lpState_r == ALC_CAL) : background_cal_enable;

endmodule : alc_cal_regs

// file: src/alc_interval_timer.sv
`timescale 1ns/1ps
// Counts (2^k + 1) x 256 clock periods once started; done pulses at the end.
module alc_interval_timer
	import alc_pkg::*;
#(
	parameter int SHIFT_CAP = 33
)
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst,
	input  wire logic                 clear,
	input  wire logic                 start,
	input  wire logic [EXP_WIDTH-1:0] expK,
	output logic                      done
);

	logic [INTERVAL_WIDTH-1:0] count_r;
	logic [INTERVAL_WIDTH-1:0] target;
	logic                      run_r;

	// The length is formed from the exponent so no wide lookup is stored.
	always_comb
	begin
		target = ((INTERVAL_WIDTH'(1) << expK) + INTERVAL_WIDTH'(1)) * INTERVAL_WIDTH'(UNIT_CYCLES);
	end

	// Counter clears and stops on clear so a disabled mode never leaves stale time.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			count_r <= '0;
			run_r   <= 1'b0;
			done    <= 1'b0;
		end
		else if (clear)
		begin
			count_r <= '0;
			run_r   <= 1'b0;
			done    <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				// Starts at three: the start register, this load and the done register each cost a clock.
				count_r <= INTERVAL_WIDTH'(3);
				run_r   <= 1'b1;
			end
			else if (run_r)
			begin
				if (count_r == target)
				begin
					run_r <= 1'b0;
					done  <= 1'b1;
				end
				else
				begin
					count_r <= count_r + INTERVAL_WIDTH'(1);
				end
			end
		end
	end

endmodule : alc_interval_timer

// file: src/alc_pkg.sv
package alc_pkg;

	// ****************************************************************
	// Register offsets.
	// ****************************************************************
	localparam logic [7:0] LP_CTRL_OFS      = 8'h6E;
	localparam logic [7:0] VEC_EN_OFS       = 8'h70;
	localparam logic [7:0] VEC_PORT_OFS     = 8'h71;
	localparam logic [7:0] GAIN_A_OFS       = 8'h7A;
	localparam logic [7:0] GAIN_B_OFS       = 8'h7B;
	localparam logic [7:0] BANDGAP_OFS      = 8'h7C;
	localparam logic [7:0] TERM_A_OFS       = 8'h7E;
	localparam logic [7:0] TERM_B_OFS       = 8'h7F;
	localparam logic [7:0] DITHER_OFS       = 8'h9D;

	// ****************************************************************
	// Field positions.
	// ****************************************************************
	localparam int SLEEP_SEL_LSB   = 5;
	localparam int SETTLE_SEL_LSB  = 3;
	localparam int LP_RSVD_BIT     = 2;
	localparam int TRIG_WAKE_BIT   = 1;
	localparam int LP_ENABLE_BIT   = 0;
	localparam int VEC_EN_BIT      = 0;
	localparam int DITH_EN_BIT     = 0;
	localparam int DITH_AMP_BIT    = 1;
	localparam int DITH_ERR_BIT    = 2;
	localparam int BANDGAP_WIDTH   = 4;

	// ****************************************************************
	// Reset values.
	// ****************************************************************
	localparam logic [7:0] LP_CTRL_RST  = 8'h88;
	localparam logic [7:0] VEC_EN_RST   = 8'h00;
	localparam logic [7:0] DITHER_RST   = 8'h01;

	// ****************************************************************
	// Timing: every interval is (2^k + 1) x UNIT_CYCLES clock periods.
	// ****************************************************************
	localparam int UNIT_CYCLES     = 256;
	localparam int VEC_LENGTH      = 673;
	localparam int EXP_WIDTH       = 6;
	localparam int INTERVAL_WIDTH  = 42;

	typedef enum {ALC_IDLE, ALC_SLEEP, ALC_SETTLE, ALC_CAL} alc_lp_state_e;

endpackage : alc_pkg

// file: src/alc_sync3.sv
`timescale 1ns/1ps
// Three-stage input synchroniser; a change counts once stages two and three agree.
module alc_sync3
(
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic asyncIn,
	input  wire logic resetLevel,
	output logic      syncOut
);

	logic stage1_r;
	logic stage2_r;
	logic stage3_r;

	// Reset to a constant high, the idle level of the trigger pin.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			stage1_r <= 1'b1;
			stage2_r <= 1'b1;
			stage3_r <= 1'b1;
			syncOut  <= 1'b1;
		end
		else
		begin
			stage1_r <= asyncIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			if (stage2_r == stage3_r)
			begin
				syncOut <= stage3_r;
			end
		end
	end

	// The reset level input is unused by the filter but kept for symmetry.
	logic unusedLevel;
	assign unusedLevel = resetLevel;

endmodule : alc_sync3

// file: test/alc_cal_regs_bench.sv
`timescale 1ns/1ps
// ****
// Self-checking bench for the calibration register block.
// ****
module alc_cal_regs_bench
	import alc_pkg::*;
;
	logic       sys_clk, rst, regWrite, regRead, bgOn, srcSel, softTrig, trigPin, halted;
	logic       coreAwake, calRequest, calDataValid, dithEn, dithAmp, roundSel;
	logic [7:0] regAddr, regWdata, regRdata, gainA, gainB, termA, termB, got, d, seed;
	logic [3:0] bandgap;
	logic [7:0] ev[6];
	logic [7:0] addrs[6] = '{GAIN_A_OFS, GAIN_B_OFS, BANDGAP_OFS, TERM_A_OFS, TERM_B_OFS, DITHER_OFS};
	logic [7:0] masks[6] = '{8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h07};
	logic [7:0] rstv[6]  = '{8'h5A, 8'hA5, 8'h03, 8'h3C, 8'hC3, DITHER_RST};
	int         n_errors, comparisons, cycles, n;

	alc_cal_regs #(.FUSE_GAIN_A(8'h5A), .FUSE_GAIN_B(8'hA5), .FUSE_BANDGAP(4'h3),
		.FUSE_TERM_A(8'h3C), .FUSE_TERM_B(8'hC3)) u_alc_cal_regs (.sys_clk(sys_clk),
		.rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
		.regWdata(regWdata), .regRdata(regRdata), .background_cal_enable(bgOn),
		.trigger_source_sel(srcSel), .soft_calib_trigger(softTrig),
		.calib_trigger_pin(trigPin), .calibHalted(halted), .coreAwake(coreAwake),
		.calRequest(calRequest), .calDataValid(calDataValid), .gainAdjustA(gainA),
		.gainAdjustB(gainB), .bandgapAdjust(bandgap), .termAdjustA(termA),
		.termAdjustB(termB), .dither_enable(dithEn), .dither_amplitude_sel(dithAmp),
		.rounding_error_sel(roundSel));

	alc_host_model u_alc_host_model (.sys_clk(sys_clk), .calibHalted(halted),
		.regRdata(regRdata), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata));

	// Free-running clock, 8 ns period.
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	function automatic logic [7:0] lfsrNext(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction : lfsrNext

	// Interval length in clocks for exponent k: (2^k + 1) units.
	function automatic int intervalClocks(input int k);
		return ((2 ** k) + 1) * UNIT_CYCLES;
	endfunction : intervalClocks

	task automatic check(input string what, input logic [39:0] expv, input logic [39:0] seen);
		comparisons++;
		if (seen !== expv)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, expv, seen);
		end
	endtask : check

	// Counts falling edges while the two low-power outputs keep the given levels.
	task automatic measure(input logic aw, input logic cr, output int cnt);
		cnt = 0;
		while ({coreAwake, calRequest} === {aw, cr} && cnt < 8000)
		begin
			@(negedge sys_clk);
			cnt++;
		end
	endtask : measure

	task automatic complete_run;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	// Cuts a hang short; the full run needs roughly 23000 clocks.
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			n_errors++;
			complete_run();
		end
	end

	// Main sequence: reset values, random trims, vector port, low-power modes.
	initial
	begin
		rst = 1'b1;
		{bgOn, srcSel, halted, trigPin, softTrig} = 5'b00111;
		{n_errors, comparisons, cycles} = '0;
		seed = 8'h35;
		repeat (2) @(negedge sys_clk);
		rst = 1'b0;
		u_alc_host_model.rd(LP_CTRL_OFS, got);
		check("lp reset", LP_CTRL_RST, got);
		u_alc_host_model.rd(VEC_EN_OFS, got);
		check("vec enable reset", VEC_EN_RST, got);
		for (int i = 0; i < 6; i++)
		begin
			u_alc_host_model.rd(addrs[i], got);
			check("reset value", rstv[i], got);
		end
		u_alc_host_model.wr(8'h6F, 8'hFF);
		u_alc_host_model.rd(8'h6F, got);
		check("unmapped", 8'h00, got);
		repeat (8)
		begin
			for (int i = 0; i < 6; i++)
			begin
				seed = lfsrNext(seed);
				ev[i] = seed;
				u_alc_host_model.wr(addrs[i], seed);
				u_alc_host_model.rd(addrs[i], got);
				check("readback", seed & masks[i], got & masks[i]);
			end
			check("trim ports", {ev[0], ev[1], ev[2][3:0], ev[3], ev[4], ev[5][2:0]},
				{gainA, gainB, bandgap, termA, termB, roundSel, dithAmp, dithEn});
		end
		u_alc_host_model.rd(VEC_PORT_OFS, got);
		check("closed port", 8'h00, got);
		u_alc_host_model.wr(VEC_EN_OFS, 8'h01);
		d = seed;
		for (int i = 0; i < VEC_LENGTH; i++)
		begin
			u_alc_host_model.wr(VEC_PORT_OFS, d);
			d = lfsrNext(d);
		end
		d = seed;
		for (int i = 0; i < VEC_LENGTH; i++)
		begin
			u_alc_host_model.rd(VEC_PORT_OFS, got);
			check("vector byte", d, got);
			d = lfsrNext(d);
		end
		check("valid after full", 1'b1, calDataValid);
		repeat (3) u_alc_host_model.wr(VEC_PORT_OFS, seed);
		u_alc_host_model.wr(VEC_EN_OFS, 8'h00);
		check("valid after short", 1'b0, calDataValid);
		halted = 1'b0;
		u_alc_host_model.wr(LP_CTRL_OFS, 8'h01);
		repeat (3000) @(negedge sys_clk);
		check("awake without bg", 1'b1, coreAwake);
		bgOn = 1'b1;
		measure(1'b1, 1'b0, n);
		measure(1'b0, 1'b0, n);
		check("sleep clocks", intervalClocks(3), n);
		measure(1'b1, 1'b0, n);
		check("settle clocks", intervalClocks(3), n);
		measure(1'b1, 1'b1, n);
		check("cal slot", 16, n);
		check("asleep again", 1'b0, coreAwake);
		u_alc_host_model.wr(LP_CTRL_OFS, 8'h03);
		for (int s = 0; s < 2; s++)
		begin
			srcSel = s[0];
			{trigPin, softTrig} = s[0] ? 2'b10 : 2'b01;
			n = 0;
			while (coreAwake !== 1'b0 && n < 6000)
			begin
				@(negedge sys_clk);
				n++;
			end
			repeat (3000) @(negedge sys_clk);
			check("held asleep", 1'b0, coreAwake);
			{trigPin, softTrig} = 2'b00;
			n = 0;
			while (coreAwake !== 1'b1 && n < 20)
			begin
				@(negedge sys_clk);
				n++;
			end
			check("trigger wake", 1'b1, coreAwake);
			{trigPin, softTrig} = 2'b11;
		end
		u_alc_host_model.wr(LP_CTRL_OFS, 8'h00);
		repeat (4) @(negedge sys_clk);
		check("lp off awake", 1'b1, coreAwake);
		u_alc_host_model.wr(LP_CTRL_OFS, LP_CTRL_RST | 8'h01);
		repeat (3000) @(negedge sys_clk);
		check("long sleep held", 1'b0, coreAwake);
		complete_run();
	end
endmodule : alc_cal_regs_bench

// file: test/alc_cal_regs_monitor.sv
`timescale 1ns/1ps
// ****
// Port checker for the calibration register block.
// ****
module alc_cal_regs_monitor
	import alc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       regWrite,
	input wire logic       regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic [7:0] regRdata,
	input wire logic       background_cal_enable,
	input wire logic       coreAwake,
	input wire logic       calRequest,
	input wire logic [7:0] gainAdjustA,
	input wire logic [3:0] bandgapAdjust,
	input wire logic [7:0] termAdjustB,
	input wire logic       dither_enable,
	input wire logic       dither_amplitude_sel,
	input wire logic       rounding_error_sel
);
	localparam logic [15:0] SHORTEST = 16'h0900; // Code 0 interval, nine units of 256.

	logic [7:0]  lpMirror_r;
	logic        vecOpen_r;
	logic [15:0] sleepCnt_r;
	logic [15:0] settleCnt_r;
	logic        lpOn;
	logic        autoShort;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Mirrors of the control bits that decide how the outputs must behave.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			lpMirror_r <= LP_CTRL_RST;
			vecOpen_r  <= 1'b0;
		end
		else if (regWrite && regAddr == LP_CTRL_OFS)
			lpMirror_r <= regWdata;
		else if (regWrite && regAddr == VEC_EN_OFS)
			vecOpen_r <= regWdata[VEC_EN_BIT];
	end

	// Clocks spent asleep, and clocks spent awake before a calibration slot.
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sleepCnt_r  <= 16'h0000;
			settleCnt_r <= 16'h0000;
		end
		else
		begin
			sleepCnt_r  <= coreAwake ? 16'h0000 : sleepCnt_r + 16'h0001;
			settleCnt_r <= (coreAwake && !calRequest) ? settleCnt_r + 16'h0001 : 16'h0000;
		end
	end

	// Only the shortest codes are judged, since longer ones outlast any run.
	assign lpOn      = lpMirror_r[0] && background_cal_enable && lpMirror_r[4:3] == 2'b00;
	assign autoShort = lpOn && lpMirror_r[7:5] == 3'b000 && !lpMirror_r[1];

	sequence s_closed_read;
		regRead && regAddr == VEC_PORT_OFS && !vecOpen_r ##1 !regRead;
	endsequence

	sequence s_bg_off;
		!background_cal_enable [*3];
	endsequence

	a_closed_port_read: assert property (s_closed_read |=> regRdata == 8'h00)
		else $error("vector port answered while closed");
	a_dither_write: assert property (regWrite && regAddr == DITHER_OFS
		|=> {rounding_error_sel, dither_amplitude_sel, dither_enable} == $past(regWdata[2:0]))
		else $error("dither bits did not follow a write");
	a_gain_write: assert property (regWrite && regAddr == GAIN_A_OFS
		|=> gainAdjustA == $past(regWdata))
		else $error("gain trim did not follow a write");
	a_bandgap_write: assert property (regWrite && regAddr == BANDGAP_OFS
		|=> bandgapAdjust == $past(regWdata[3:0]))
		else $error("reference trim did not follow a write");
	a_term_hold: assert property (!(regWrite && regAddr == TERM_B_OFS)
		|=> $stable(termAdjustB))
		else $error("termination trim changed without a write");
	a_lp_needs_bg: assert property (s_bg_off |-> coreAwake)
		else $error("core slept with background calibration off");
	a_sleep_length: assert property ($rose(coreAwake) && autoShort
		|-> sleepCnt_r == SHORTEST)
		else $error("sleep interval length wrong");
	a_settle_length: assert property ($rose(calRequest) && lpOn
		|-> settleCnt_r == SHORTEST)
		else $error("settling interval length wrong");
endmodule : alc_cal_regs_monitor

bind alc_cal_regs alc_cal_regs_monitor u_alc_cal_regs_monitor (
	.sys_clk,
	.rst,
	.regWrite,
	.regRead,
	.regAddr,
	.regWdata,
	.regRdata,
	.background_cal_enable,
	.coreAwake,
	.calRequest,
	.gainAdjustA,
	.bandgapAdjust,
	.termAdjustB,
	.dither_enable,
	.dither_amplitude_sel,
	.rounding_error_sel
);

// file: test/alc_host_model.sv
`timescale 1ns/1ps
// ****
// Host side of the register interface: one access at a time.
// ****
module alc_host_model
	import alc_pkg::*;
(
	input wire logic       sys_clk,
	input wire logic       calibHalted,
	input wire logic [7:0] regRdata,
	output logic           regWrite,
	output logic           regRead,
	output logic     [7:0] regAddr,
	output logic     [7:0] regWdata
);
	// Idle bus at time zero.
	initial
	begin
		regWrite = 1'b0;
		regRead  = 1'b0;
		regAddr  = 8'h00;
		regWdata = 8'h00;
	end

	// The vector port is touched only while calibration is halted, else it corrupts.
	task automatic waitHalt(input logic [7:0] a);
		if (a == VEC_PORT_OFS)
			wait (calibHalted === 1'b1);
		@(negedge sys_clk);
	endtask : waitHalt

	// Address and data are inverted when released so stale values never look valid.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		waitHalt(a);
		regAddr  = a;
		regWdata = (a == LP_CTRL_OFS) ? (d & 8'hFB) : d;
		regWrite = 1'b1;
		@(negedge sys_clk);
		regWrite = 1'b0;
		regAddr  = ~regAddr;
		regWdata = ~regWdata;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		waitHalt(a);
		regAddr = a;
		regRead = 1'b1;
		@(negedge sys_clk);
		regRead = 1'b0;
		regAddr = ~regAddr;
		@(negedge sys_clk);
		d = regRdata;
	endtask : rd
endmodule : alc_host_model
